// *** design/rx_irq_pkg.sv ***
/*
 * Constants for the receive framer event interrupt registers:
 * register indices and byte addresses, bit positions, reset values,
 * the long-message length limit and the register select enumeration.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
// Contract
// - Zero-run change enable at bit 0, read/write, 1 permits, resets to 0.
// - Enabled zero-run change interrupts on both start and end of the condition.
// - Long-message flag at bit 0 reads 1 if event since last read; clears on read.
// - Long-message event when a received LAPD message exceeds 276 bytes.
// - Long-message enable at bit 0: 0 disables, 1 enables.
// - Enabled line-loss change interrupts on both declare and clear of loss.
// - Line-loss change flag at bit 3, clear on read; bits 7 to 4 reserved.
// - Line-loss enable at bit 3 inverted: 0 enables, 1 disables; resets to 0.
// - Zero-run change flag latched at bit 0 of its status register, clear on read.
package rx_irq_pkg;
   localparam int APB_AW = 16;
   localparam int APB_DW = 32;
   localparam int LEN_W = 11;

   // printed offsets are register indices; byte address is four times the index
   localparam logic [11:0] IDX_ZERO_STAT = 12'hb0f;
   localparam logic [11:0] IDX_ZERO_EN = 12'hb10;
   localparam logic [11:0] IDX_LONG_STAT = 12'hb11;
   localparam logic [11:0] IDX_LONG_EN = 12'hb12;
   localparam logic [11:0] IDX_LOSS_STAT = 12'hb13;
   localparam logic [11:0] IDX_LOSS_EN = 12'hb14;

   localparam logic [15:0] ADDR_ZERO_STAT = {2'b00, IDX_ZERO_STAT, 2'b00};
   localparam logic [15:0] ADDR_ZERO_EN = {2'b00, IDX_ZERO_EN, 2'b00};
   localparam logic [15:0] ADDR_LONG_STAT = {2'b00, IDX_LONG_STAT, 2'b00};
   localparam logic [15:0] ADDR_LONG_EN = {2'b00, IDX_LONG_EN, 2'b00};
   localparam logic [15:0] ADDR_LOSS_STAT = {2'b00, IDX_LOSS_STAT, 2'b00};
   localparam logic [15:0] ADDR_LOSS_EN = {2'b00, IDX_LOSS_EN, 2'b00};

   localparam int ZERO_BIT = 0;
   localparam int LONG_BIT = 0;
   localparam int LOSS_BIT = 3;

   localparam logic RST_FLAG = 1'b0;
   localparam logic RST_ZERO_EN = 1'b0;
   localparam logic RST_LONG_EN = 1'b0;
   localparam logic RST_LOSS_DIS = 1'b0;

   localparam logic [LEN_W-1:0] MAX_MSG_BYTES = 11'd276;

   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_ZERO_STAT,
      SEL_ZERO_EN,
      SEL_LONG_STAT,
      SEL_LONG_EN,
      SEL_LOSS_STAT,
      SEL_LOSS_EN
   } reg_sel_e;
endpackage

// *** design/rx_framer_event_irq_regs.sv ***
/*
 * Receive framer event interrupt registers for one channel: zero-run
 * change, long LAPD message on data-link controller 1 and line-loss
 * change, each with a sticky flag and an enable, behind an APB slave.
 * Assumes detector levels and the message-done strobe come from logic
 * on pclk; the APB master keeps to the standard two-phase protocol.
 */
`timescale 1ns/1ps
module rx_framer_event_irq_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [rx_irq_pkg::APB_AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [rx_irq_pkg::APB_DW-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [rx_irq_pkg::APB_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic zero_run_active,
   input wire logic line_loss_active,
   input wire logic lapd1_msg_done,
   input wire logic [rx_irq_pkg::LEN_W-1:0] lapd1_msg_len,
   output logic irq
);
   import rx_irq_pkg::*;

   function automatic reg_sel_e decode(input logic [APB_AW-1:0] a);
      reg_sel_e s;
      s = SEL_NONE;
      case (a)
         ADDR_ZERO_STAT: s = SEL_ZERO_STAT;
         ADDR_ZERO_EN: s = SEL_ZERO_EN;
         ADDR_LONG_STAT: s = SEL_LONG_STAT;
         ADDR_LONG_EN: s = SEL_LONG_EN;
         ADDR_LOSS_STAT: s = SEL_LOSS_STAT;
         ADDR_LOSS_EN: s = SEL_LOSS_EN;
         default: s = SEL_NONE;
      endcase
      return s;
   endfunction

   reg_sel_e sel;
   logic setup_rd;
   logic access;
   logic rd_access;
   logic wr_access;
   logic [APB_DW-1:0] rd_word;
   logic [APB_DW-1:0] prdata_q;

   logic zero_flag_q;
   logic long_flag_q;
   logic loss_flag_q;
   logic zero_en_q;
   logic long_en_q;
   logic loss_dis_q;
   logic irq_q;

   logic primed_q;
   logic zero_prev_q;
   logic loss_prev_q;
   logic zero_change;
   logic loss_change;
   logic long_event;

   logic zero_clr;
   logic long_clr;
   logic loss_clr;
   logic pending;

   assign sel = decode(paddr);
   assign setup_rd = psel & ~penable & ~pwrite;
   assign access = psel & penable;
   assign rd_access = access & ~pwrite;
   assign wr_access = access & pwrite & pstrb[0];

   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access & (sel == SEL_NONE);
   assign prdata = prdata_q;

   always_comb begin
      rd_word = '0;
      case (sel)
         SEL_ZERO_STAT: rd_word[ZERO_BIT] = zero_flag_q;
         SEL_ZERO_EN: rd_word[ZERO_BIT] = zero_en_q;
         SEL_LONG_STAT: rd_word[LONG_BIT] = long_flag_q;
         SEL_LONG_EN: rd_word[LONG_BIT] = long_en_q;
         SEL_LOSS_STAT: rd_word[LOSS_BIT] = loss_flag_q;
         SEL_LOSS_EN: rd_word[LOSS_BIT] = loss_dis_q;
         default: rd_word = '0;
      endcase
   end

   // read data is captured in the setup cycle so the access edge can clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (setup_rd) begin
         prdata_q <= rd_word;
      end
   end

   // change detectors are primed one cycle after reset to avoid a false edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         primed_q <= 1'b0;
         zero_prev_q <= 1'b0;
         loss_prev_q <= 1'b0;
      end else begin
         primed_q <= 1'b1;
         zero_prev_q <= zero_run_active;
         loss_prev_q <= line_loss_active;
      end
   end

   assign zero_change = primed_q & (zero_run_active != zero_prev_q);
   assign loss_change = primed_q & (line_loss_active != loss_prev_q);
   assign long_event = lapd1_msg_done & (lapd1_msg_len > MAX_MSG_BYTES);

   // clear only what the read returned, or a written one
   assign zero_clr = (rd_access & (sel == SEL_ZERO_STAT) & prdata_q[ZERO_BIT])
                   | (wr_access & (sel == SEL_ZERO_STAT) & pwdata[ZERO_BIT]);
   assign long_clr = (rd_access & (sel == SEL_LONG_STAT) & prdata_q[LONG_BIT])
                   | (wr_access & (sel == SEL_LONG_STAT) & pwdata[LONG_BIT]);
   assign loss_clr = (rd_access & (sel == SEL_LOSS_STAT) & prdata_q[LOSS_BIT])
                   | (wr_access & (sel == SEL_LOSS_STAT) & pwdata[LOSS_BIT]);

   // a new event wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_flag_q <= RST_FLAG;
      end else if (zero_change) begin
         zero_flag_q <= 1'b1;
      end else if (zero_clr) begin
         zero_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         long_flag_q <= RST_FLAG;
      end else if (long_event) begin
         long_flag_q <= 1'b1;
      end else if (long_clr) begin
         long_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loss_flag_q <= RST_FLAG;
      end else if (loss_change) begin
         loss_flag_q <= 1'b1;
      end else if (loss_clr) begin
         loss_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         zero_en_q <= RST_ZERO_EN;
      end else if (wr_access && sel == SEL_ZERO_EN) begin
         zero_en_q <= pwdata[ZERO_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         long_en_q <= RST_LONG_EN;
      end else if (wr_access && sel == SEL_LONG_EN) begin
         long_en_q <= pwdata[LONG_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loss_dis_q <= RST_LOSS_DIS;
      end else if (wr_access && sel == SEL_LOSS_EN) begin
         loss_dis_q <= pwdata[LOSS_BIT];
      end
   end

   // enables gate the output only; flags latch whatever the enable
   assign pending = (zero_flag_q & zero_en_q)
                  | (long_flag_q & long_en_q)
                  | (loss_flag_q & ~loss_dis_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= pending;
      end
   end

   assign irq = irq_q;

   chk_zero_en_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_access && sel == SEL_ZERO_EN) |=> (zero_en_q == $past(pwdata[ZERO_BIT])))
      else $error("zero-run enable did not take the written value");

   chk_zero_both_edges: assert property (
      @(posedge pclk) disable iff (!presetn)
      (primed_q && $changed(zero_run_active)) |=> zero_flag_q)
      else $error("zero-run change did not set its flag");

   chk_long_read_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_access && sel == SEL_LONG_STAT && prdata_q[LONG_BIT] && !long_event)
      |=> !long_flag_q)
      else $error("long-message flag not cleared by read");

   chk_long_limit: assert property (
      @(posedge pclk) disable iff (!presetn)
      (lapd1_msg_done && lapd1_msg_len > MAX_MSG_BYTES) |=> long_flag_q)
      else $error("message over limit did not set the flag");

   chk_long_short_msg: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!long_flag_q && lapd1_msg_done && lapd1_msg_len <= MAX_MSG_BYTES) |=> !long_flag_q)
      else $error("message within limit set the flag");

   chk_long_en_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (long_flag_q && !long_en_q && !zero_flag_q && !loss_flag_q) |=> !irq)
      else $error("disabled long-message event raised the interrupt");

   chk_loss_both_edges: assert property (
      @(posedge pclk) disable iff (!presetn)
      (primed_q && $changed(line_loss_active)) |=> loss_flag_q)
      else $error("line-loss change did not set its flag");

   chk_loss_readback: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_rd && sel == SEL_LOSS_STAT)
      |=> (prdata[7:4] == 4'h0 && prdata[LOSS_BIT] == $past(loss_flag_q)))
      else $error("line-loss status read back wrong");

   chk_loss_inverted: assert property (
      @(posedge pclk) disable iff (!presetn)
      (loss_flag_q && !loss_dis_q) |=> irq)
      else $error("line-loss flag with enable at 0 gave no interrupt");

   chk_zero_readback: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_rd && sel == SEL_ZERO_STAT)
      ##1 (rd_access && sel == SEL_ZERO_STAT && !zero_change)
      |=> (zero_flag_q == ($past(zero_flag_q) & ~prdata_q[ZERO_BIT])))
      else $error("zero-run flag read and clear mismatch");

   chk_irq_drop: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!pending) [*2] |-> !irq)
      else $error("interrupt stayed high with nothing pending");

   chk_irq_raise: assert property (
      @(posedge pclk) disable iff (!presetn)
      pending |=> irq)
      else $error("pending event gave no interrupt");

   // enable writes land only with the low byte strobe on a mapped address
   chk_long_en_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_access && sel == SEL_LONG_EN) |=> (long_en_q == $past(pwdata[LONG_BIT])))
      else $error("long-message enable did not take the written value");

   chk_loss_en_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_access && sel == SEL_LOSS_EN) |=> (loss_dis_q == $past(pwdata[LOSS_BIT])))
      else $error("line-loss enable did not take the written value");

   chk_strobe_off_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      (access && pwrite && !pstrb[0])
      |=> ($stable(zero_en_q) && $stable(long_en_q) && $stable(loss_dis_q)))
      else $error("write without the low byte strobe changed an enable");

   // each enable gates only its own flag onto the interrupt
   chk_zero_en_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (zero_flag_q && !zero_en_q && !long_flag_q && !loss_flag_q) |=> !irq)
      else $error("disabled zero-run event raised the interrupt");

   chk_zero_en_raise: assert property (
      @(posedge pclk) disable iff (!presetn)
      (zero_flag_q && zero_en_q) |=> irq)
      else $error("enabled zero-run flag gave no interrupt");

   chk_long_en_raise: assert property (
      @(posedge pclk) disable iff (!presetn)
      (long_flag_q && long_en_q) |=> irq)
      else $error("enabled long-message flag gave no interrupt");

   chk_loss_dis_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (loss_flag_q && loss_dis_q && !zero_flag_q && !long_flag_q) |=> !irq)
      else $error("line-loss flag with enable at 1 raised the interrupt");

   // a read that returned one clears the flag unless a new event arrives
   chk_zero_read_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_access && sel == SEL_ZERO_STAT && prdata_q[ZERO_BIT] && !zero_change)
      |=> !zero_flag_q)
      else $error("zero-run flag not cleared by read");

   chk_loss_read_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_access && sel == SEL_LOSS_STAT && prdata_q[LOSS_BIT] && !loss_change)
      |=> !loss_flag_q)
      else $error("line-loss flag not cleared by read");

   chk_long_readback: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup_rd && sel == SEL_LONG_STAT)
      |=> (prdata[APB_DW-1:1] == '0 && prdata[LONG_BIT] == $past(long_flag_q)))
      else $error("long-message status read back wrong");

   // flags rise only on their own events
   chk_zero_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!zero_flag_q && !zero_change) |=> !zero_flag_q)
      else $error("zero-run flag set with no change of the condition");

   chk_loss_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!loss_flag_q && !loss_change) |=> !loss_flag_q)
      else $error("line-loss flag set with no change of the condition");

   chk_long_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!long_flag_q && !long_event) |=> !long_flag_q)
      else $error("long-message flag set with no long message");

   // an event in the clearing cycle must not be lost
   chk_loss_event_wins: assert property (
      @(posedge pclk) disable iff (!presetn)
      (loss_change && loss_clr) |=> loss_flag_q)
      else $error("clear in the event cycle lost a line-loss change");

   chk_zero_event_wins: assert property (
      @(posedge pclk) disable iff (!presetn)
      (zero_change && zero_clr) |=> zero_flag_q)
      else $error("clear in the event cycle lost a zero-run change");
endmodule

// *** tb/test_rx_framer_event_irq_regs.sv ***
/*
 * Self-checking bench for the receive framer event interrupt registers.
 * Assumes the design package and the design module; the bench is the APB master.
 */
`timescale 1ns/1ps
module test_rx_framer_event_irq_regs;
   import rx_irq_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic zero_run_active, line_loss_active, lapd1_msg_done, er;
   logic [APB_AW-1:0] paddr;
   logic [APB_DW-1:0] pwdata, prdata, rd, d;
   logic [3:0] pstrb;
   logic [LEN_W-1:0] lapd1_msg_len;
   int n_fail, checks_done, zf, sf, lf, ze, se, ld;
   rx_framer_event_irq_regs dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .zero_run_active(zero_run_active),
      .line_loss_active(line_loss_active), .lapd1_msg_done(lapd1_msg_done),
      .lapd1_msg_len(lapd1_msg_len), .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(string name, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask
   task apb(logic wr, logic [15:0] a, logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rdchk(string name, logic [15:0] a, logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, exp, rd);
      chk("pslverr", 32'h0, {31'h0, er});
   endtask
   function logic exp_irq();
      return (zf != 0 && ze != 0) || (sf != 0 && se != 0) || (lf != 0 && ld == 0);
   endfunction
   // settle, check irq, then read every status register, which clears it
   task look;
      @(negedge pclk);
      chk("irq", {31'h0, exp_irq()}, {31'h0, irq});
      @(posedge pclk);
      rdchk("zero_stat", ADDR_ZERO_STAT, zf);
      rdchk("long_stat", ADDR_LONG_STAT, sf);
      rdchk("loss_stat", ADDR_LOSS_STAT, lf << 3);
      zf = 0;
      sf = 0;
      lf = 0;
      @(negedge pclk);
      chk("irq_clear", 32'h0, {31'h0, irq});
      @(posedge pclk);
   endtask
   task toggle(bit loss);
      if (loss)
         line_loss_active <= ~line_loss_active;
      else
         zero_run_active <= ~zero_run_active;
      repeat (3) @(posedge pclk);
      if (loss)
         lf = 1;
      else
         zf = 1;
   endtask
   task msg(logic [LEN_W-1:0] len);
      lapd1_msg_len <= len;
      lapd1_msg_done <= 1'b1;
      @(posedge pclk);
      lapd1_msg_done <= 1'b0;
      repeat (3) @(posedge pclk);
      if (len > 11'd276)
         sf = 1;
   endtask
   task wr_en(logic [15:0] a, logic [31:0] wd, logic [31:0] exp);
      apb(1'b1, a, wd);
      rdchk("enable", a, exp);
   endtask
   initial begin
      #200us;
      n_fail++;
      report_and_stop();
   end
   initial begin
      {psel, penable, pwrite, zero_run_active, line_loss_active, lapd1_msg_done} = '0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hf;
      lapd1_msg_len = '0;
      presetn = 1'b0;
      {zf, sf, lf, ze, se, ld} = '0;
      void'($urandom(81));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rdchk("zero_en", ADDR_ZERO_EN, 32'h0);
      rdchk("long_en", ADDR_LONG_EN, 32'h0);
      rdchk("loss_en", ADDR_LOSS_EN, 32'h0);
      look();
      apb(1'b0, 16'h0000, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, er});
      chk("unmapped_data", 32'h0, rd);
      d = $urandom();
      wr_en(ADDR_ZERO_EN, d, {31'h0, d[0]});
      wr_en(ADDR_ZERO_EN, 32'hffffffff, 32'h1);
      ze = 1;
      toggle(1'b0);
      look();
      toggle(1'b0);
      look();
      wr_en(ADDR_ZERO_EN, 32'h0, 32'h0);
      ze = 0;
      toggle(1'b0);
      look();
      toggle(1'b1);
      look();
      toggle(1'b1);
      look();
      wr_en(ADDR_LOSS_EN, 32'hffffffff, 32'h8);
      ld = 1;
      toggle(1'b1);
      look();
      wr_en(ADDR_LONG_EN, 32'hffffffff, 32'h1);
      se = 1;
      msg(11'd276);
      look();
      msg(11'd277);
      look();
      msg(11'd277 + 11'($urandom_range(1770)));
      @(negedge pclk);
      chk("irq_long", 32'h1, {31'h0, irq});
      @(posedge pclk);
      apb(1'b1, ADDR_LONG_STAT, 32'h1);
      sf = 0;
      look();
      wr_en(ADDR_LONG_EN, 32'h0, 32'h0);
      se = 0;
      msg(11'h7ff);
      look();
      pstrb <= 4'he;
      apb(1'b1, ADDR_LONG_EN, 32'h1);
      pstrb <= 4'hf;
      rdchk("long_en_strb", ADDR_LONG_EN, 32'h0);
      presetn <= 1'b0;
      {zf, sf, lf, ze, se, ld} = '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rdchk("loss_en_rst", ADDR_LOSS_EN, 32'h0);
      look();
      toggle(1'b1);
      look();
      report_and_stop();
   end
endmodule
